// ### rtl/dtc_core.sv
// dual 16-bit timer/counter core with mode and control registers
// assumes one core clock, async active-high reset, and a same-clock register port;
// event and gating pins are asynchronous and get synchronised here
//
// Behaviour
// R1: each timer is a high byte and a low byte; mode joins or separates them
// R2: timer function counts once per machine cycle of twelve core clocks
// R3: counter function counts falling edges on the timer's event pin
// R4: event pin sampled once per machine cycle; count when high then low
// R5: new count appears at the update phase of the following machine cycle
// R6: outside source holds each event level at least one machine cycle
// R7: timer one gated by its gating pin when gate bit seven set
// R8: timer one source bit six picks event pin or machine cycles
// R9: timer one mode: prescaled, cascaded, auto-reload, or stopped
// R10: timer one mode three halts its count
// R11: timer zero gated by its gating pin when gate bit three set
// R12: timer zero source bit two picks event pin or machine cycles
// R13: timer zero mode zero: five-bit prescaler ahead of high byte counter
// R14: timer zero mode one: sixteen-bit cascaded counter
// R15: timer zero mode two: low byte reloads from high byte on overflow
// R16: timer zero mode three: low byte full timer, high byte uses timer one run/flag
// R17: mode register resets to zero, written only as whole byte
// R18: control register resets to zero, bits individually writable
// R19: overflow sets flag; cleared by interrupt vector acknowledge
// R20: software sets run bit to start timer, clears it to stop
// R21: auto-reload leaves the high byte unchanged
// R22: prescaled mode counts 13 bits; upper three low bits indeterminate
`timescale 1ns/10ps
`default_nettype none

module dtc_core (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] bit_mask,
   input wire logic vector_ack_zero,
   input wire logic vector_ack_one,
   input wire logic event_pin_zero,
   input wire logic event_pin_one,
   input wire logic gating_pin_zero,
   input wire logic gating_pin_one,
   output logic [7:0] reg_rdata,
   output logic overflow_flag_zero,
   output logic overflow_flag_one
);

   // ------------------------------
   // registers and internal state
   // ------------------------------
   logic [7:0] timer_control;
   logic [7:0] timer_mode_config;
   logic [7:0] low_byte_zero;
   logic [7:0] high_byte_zero;
   logic [7:0] low_byte_one;
   logic [7:0] high_byte_one;
   logic [3:0] mc_phase;
   logic [1:0] ev_sync_zero;
   logic [1:0] ev_sync_one;
   logic [1:0] gt_sync_zero;
   logic [1:0] gt_sync_one;
   logic ev_prev_zero;
   logic ev_prev_one;
   logic edge_pend_zero;
   logic edge_pend_one;
   logic run_zero;
   logic run_one;
   logic run_high_zero;
   logic tick_low_zero;
   logic tick_high_zero;
   logic tick_one;
   logic ovf_zero;
   logic ovf_one;
   logic [7:0] next_low_byte_zero, next_high_byte_zero, next_low_byte_one, next_high_byte_one;
   logic update_slot;
   logic sample_slot;
   logic wr_ctrl;
   logic [7:0] ctrl_merged;
   dtc_pkg::dtc_mode_t mode_zero;
   dtc_pkg::dtc_mode_t mode_one;

   assign mode_zero = dtc_pkg::dtc_mode_t'(timer_mode_config[dtc_pkg::MODE_ZERO_HI_BIT:dtc_pkg::MODE_ZERO_LO_BIT]);
   assign mode_one = dtc_pkg::dtc_mode_t'(timer_mode_config[dtc_pkg::MODE_ONE_HI_BIT:dtc_pkg::MODE_ONE_LO_BIT]);
   assign update_slot = (mc_phase == dtc_pkg::UPDATE_PHASE);
   assign sample_slot = (mc_phase == dtc_pkg::SAMPLE_PHASE);
   assign wr_ctrl = reg_wr && (reg_addr == dtc_pkg::ADDR_TIMER_CONTROL);

   // ------------------------------
   // machine cycle phase divider
   // ------------------------------
   // twelve core clocks per machine cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mc_phase <= 4'h0;
      end else if (mc_phase == dtc_pkg::MC_LAST) begin
         mc_phase <= 4'h0; // R2
      end else begin
         mc_phase <= mc_phase + 4'h1;
      end
   end

   // ------------------------------
   // pin synchronisers
   // ------------------------------
   // two flops on each asynchronous pin; only the second stage is read
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ev_sync_zero <= 2'h0;
         ev_sync_one <= 2'h0;
         gt_sync_zero <= 2'h0;
         gt_sync_one <= 2'h0;
      end else begin
         ev_sync_zero <= {ev_sync_zero[0], event_pin_zero};
         ev_sync_one <= {ev_sync_one[0], event_pin_one};
         gt_sync_zero <= {gt_sync_zero[0], gating_pin_zero};
         gt_sync_one <= {gt_sync_one[0], gating_pin_one};
      end
   end

   // ------------------------------
   // event edge detection
   // ------------------------------
   // sample once per machine cycle; a high then low sample marks an edge,
   // which is held until the update slot of the next machine cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ev_prev_zero <= 1'b0;
         ev_prev_one <= 1'b0;
         edge_pend_zero <= 1'b0;
         edge_pend_one <= 1'b0;
      end else begin
         if (sample_slot) begin
            ev_prev_zero <= ev_sync_zero[1]; // R4
            ev_prev_one <= ev_sync_one[1]; // R4
            edge_pend_zero <= ev_prev_zero && !ev_sync_zero[1]; // R3 R4
            edge_pend_one <= ev_prev_one && !ev_sync_one[1]; // R3 R4
         end else if (update_slot) begin
            edge_pend_zero <= 1'b0; // R5
            edge_pend_one <= 1'b0; // R5
         end
      end
   end

   // ------------------------------
   // run enables and count ticks
   // ------------------------------
   // gate bit makes the run depend on the gating pin too
   assign run_zero = timer_control[dtc_pkg::RUN_ZERO_BIT]
      && (!timer_mode_config[dtc_pkg::GATE_ZERO_BIT] || gt_sync_zero[1]); // R11 R20
   assign run_one = timer_control[dtc_pkg::RUN_ONE_BIT]
      && (!timer_mode_config[dtc_pkg::GATE_ONE_BIT] || gt_sync_one[1]); // R7 R20
   // split-mode high byte: machine cycles only, timer one's run bit
   assign run_high_zero = timer_control[dtc_pkg::RUN_ONE_BIT]; // R16
   // ticks fire at the update slot so counts land at that phase
   assign tick_low_zero = update_slot && run_zero
      && (timer_mode_config[dtc_pkg::SRC_ZERO_BIT] ? edge_pend_zero : 1'b1); // R2 R5 R12
   assign tick_one = update_slot && run_one && (mode_one != dtc_pkg::DTC_MODE_SPLIT)
      && (timer_mode_config[dtc_pkg::SRC_ONE_BIT] ? edge_pend_one : 1'b1); // R8 R10
   assign tick_high_zero = update_slot && run_high_zero; // R16

   // ------------------------------
   // timer zero next-count logic
   // ------------------------------
   always_comb begin
      next_low_byte_zero = low_byte_zero;
      next_high_byte_zero = high_byte_zero;
      ovf_zero = 1'b0;
      ovf_one = 1'b0;
      unique case (mode_zero)
         dtc_pkg::DTC_MODE_PRESCALE: begin
            if (tick_low_zero) begin
               // 13-bit count: low five bits carry into the high byte
               next_low_byte_zero = {low_byte_zero[7:5], low_byte_zero[4:0] + 5'h01}; // R13 R22
               if (low_byte_zero[4:0] == dtc_pkg::PRESCALE_MAX) begin
                  next_high_byte_zero = high_byte_zero + 8'h01; // R13
                  ovf_zero = (high_byte_zero == 8'hFF); // R19
               end
            end
         end
         dtc_pkg::DTC_MODE_CASCADE: begin
            if (tick_low_zero) begin
               next_low_byte_zero = low_byte_zero + 8'h01; // R14
               if (low_byte_zero == 8'hFF) begin
                  next_high_byte_zero = high_byte_zero + 8'h01; // R14
                  ovf_zero = (high_byte_zero == 8'hFF); // R19
               end
            end
         end
         dtc_pkg::DTC_MODE_RELOAD: begin
            if (tick_low_zero) begin
               if (low_byte_zero == 8'hFF) begin
                  next_low_byte_zero = high_byte_zero; // R15 R21
                  ovf_zero = 1'b1; // R19
               end else begin
                  next_low_byte_zero = low_byte_zero + 8'h01;
               end
            end
         end
         dtc_pkg::DTC_MODE_SPLIT: begin
            if (tick_low_zero) begin
               next_low_byte_zero = low_byte_zero + 8'h01; // R16
               ovf_zero = (low_byte_zero == 8'hFF); // R16 R19
            end
            if (tick_high_zero) begin
               next_high_byte_zero = high_byte_zero + 8'h01; // R16
               ovf_one = (high_byte_zero == 8'hFF); // R16
            end
         end
      endcase
      // timer one drives its own flag unless timer zero has taken it
      if (mode_zero != dtc_pkg::DTC_MODE_SPLIT) begin
         ovf_one = tick_one && (
            (mode_one == dtc_pkg::DTC_MODE_PRESCALE && low_byte_one[4:0] == dtc_pkg::PRESCALE_MAX
               && high_byte_one == 8'hFF)
            || (mode_one == dtc_pkg::DTC_MODE_CASCADE && low_byte_one == 8'hFF && high_byte_one == 8'hFF)
            || (mode_one == dtc_pkg::DTC_MODE_RELOAD && low_byte_one == 8'hFF)); // R19
      end
   end

   // ------------------------------
   // timer one next-count logic
   // ------------------------------
   always_comb begin
      next_low_byte_one = low_byte_one;
      next_high_byte_one = high_byte_one;
      if (tick_one) begin
         unique case (mode_one)
            dtc_pkg::DTC_MODE_PRESCALE: begin
               next_low_byte_one = {low_byte_one[7:5], low_byte_one[4:0] + 5'h01}; // R9 R22
               if (low_byte_one[4:0] == dtc_pkg::PRESCALE_MAX) begin
                  next_high_byte_one = high_byte_one + 8'h01; // R9
               end
            end
            dtc_pkg::DTC_MODE_CASCADE: begin
               next_low_byte_one = low_byte_one + 8'h01; // R9
               if (low_byte_one == 8'hFF) begin
                  next_high_byte_one = high_byte_one + 8'h01; // R9
               end
            end
            dtc_pkg::DTC_MODE_RELOAD: begin
               next_low_byte_one = (low_byte_one == 8'hFF) ? high_byte_one : low_byte_one + 8'h01; // R9 R21
            end
            dtc_pkg::DTC_MODE_SPLIT: begin
               next_low_byte_one = low_byte_one; // R10
            end
         endcase
      end
   end

   // ------------------------------
   // count registers
   // ------------------------------
   // a software write to a count byte overrides the count in that cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         low_byte_zero <= dtc_pkg::RST_COUNT;
         high_byte_zero <= dtc_pkg::RST_COUNT;
         low_byte_one <= dtc_pkg::RST_COUNT;
         high_byte_one <= dtc_pkg::RST_COUNT;
      end else begin
         low_byte_zero <= (reg_wr && reg_addr == dtc_pkg::ADDR_LOW_BYTE_ZERO) ? reg_wdata : next_low_byte_zero; // R1
         high_byte_zero <= (reg_wr && reg_addr == dtc_pkg::ADDR_HIGH_BYTE_ZERO) ? reg_wdata : next_high_byte_zero; // R1
         low_byte_one <= (reg_wr && reg_addr == dtc_pkg::ADDR_LOW_BYTE_ONE) ? reg_wdata : next_low_byte_one; // R1
         high_byte_one <= (reg_wr && reg_addr == dtc_pkg::ADDR_HIGH_BYTE_ONE) ? reg_wdata : next_high_byte_one; // R1
      end
   end

   // ------------------------------
   // mode config register
   // ------------------------------
   // whole-byte write only
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         timer_mode_config <= dtc_pkg::RST_TIMER_MODE_CONFIG; // R17
      end else if (reg_wr && reg_addr == dtc_pkg::ADDR_TIMER_MODE_CONFIG) begin
         timer_mode_config <= reg_wdata; // R17
      end
   end

   // ------------------------------
   // timer control register
   // ------------------------------
   // bit_mask picks the bits a write touches; hardware set beats any clear
   assign ctrl_merged = (timer_control & ~bit_mask) | (reg_wdata & bit_mask); // R18
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         timer_control <= dtc_pkg::RST_TIMER_CONTROL; // R18
      end else begin
         if (wr_ctrl) begin
            timer_control <= ctrl_merged; // R18 R20
         end
         if (vector_ack_zero && !(wr_ctrl && bit_mask[dtc_pkg::OVF_ZERO_BIT])) begin
            timer_control[dtc_pkg::OVF_ZERO_BIT] <= 1'b0; // R19
         end
         if (vector_ack_one && !(wr_ctrl && bit_mask[dtc_pkg::OVF_ONE_BIT])) begin
            timer_control[dtc_pkg::OVF_ONE_BIT] <= 1'b0; // R19
         end
         if (ovf_zero) begin
            timer_control[dtc_pkg::OVF_ZERO_BIT] <= 1'b1; // R19
         end
         if (ovf_one) begin
            timer_control[dtc_pkg::OVF_ONE_BIT] <= 1'b1; // R19
         end
      end
   end

   // ------------------------------
   // register read port and flag outputs
   // ------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            dtc_pkg::ADDR_TIMER_CONTROL: reg_rdata <= timer_control;
            dtc_pkg::ADDR_TIMER_MODE_CONFIG: reg_rdata <= timer_mode_config;
            dtc_pkg::ADDR_LOW_BYTE_ZERO: reg_rdata <= low_byte_zero;
            dtc_pkg::ADDR_LOW_BYTE_ONE: reg_rdata <= low_byte_one;
            dtc_pkg::ADDR_HIGH_BYTE_ZERO: reg_rdata <= high_byte_zero;
            dtc_pkg::ADDR_HIGH_BYTE_ONE: reg_rdata <= high_byte_one;
            default: reg_rdata <= 8'h00; // unmapped reads zero
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // flag outputs mirror the control register one cycle later
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         overflow_flag_zero <= 1'b0;
         overflow_flag_one <= 1'b0;
      end else begin
         overflow_flag_zero <= timer_control[dtc_pkg::OVF_ZERO_BIT];
         overflow_flag_one <= timer_control[dtc_pkg::OVF_ONE_BIT];
      end
   end

endmodule : dtc_core

`default_nettype wire

// ### rtl/dtc_pkg.sv
// package for the dual timer/counter core: register offsets, field positions, reset values
// assumes a single 125 MHz core clock and a plain address/strobe register port
package dtc_pkg;
   // ------------------------------
   // register offsets (byte addresses on the register port)
   // ------------------------------
   localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
   localparam logic [7:0] ADDR_TIMER_MODE_CONFIG = 8'h89;
   localparam logic [7:0] ADDR_LOW_BYTE_ZERO = 8'h8A;
   localparam logic [7:0] ADDR_LOW_BYTE_ONE = 8'h8B;
   localparam logic [7:0] ADDR_HIGH_BYTE_ZERO = 8'h8C;
   localparam logic [7:0] ADDR_HIGH_BYTE_ONE = 8'h8D;
   localparam logic [7:0] ADDR_FLAG_ACK = 8'h8E;
   // ------------------------------
   // reset values
   // ------------------------------
   localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
   localparam logic [7:0] RST_TIMER_MODE_CONFIG = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   // ------------------------------
   // mode config field positions
   // ------------------------------
   localparam int GATE_ONE_BIT = 7;
   localparam int SRC_ONE_BIT = 6;
   localparam int MODE_ONE_HI_BIT = 5;
   localparam int MODE_ONE_LO_BIT = 4;
   localparam int GATE_ZERO_BIT = 3;
   localparam int SRC_ZERO_BIT = 2;
   localparam int MODE_ZERO_HI_BIT = 1;
   localparam int MODE_ZERO_LO_BIT = 0;
   // ------------------------------
   // timer control field positions
   // ------------------------------
   localparam int OVF_ONE_BIT = 7;
   localparam int RUN_ONE_BIT = 6;
   localparam int OVF_ZERO_BIT = 5;
   localparam int RUN_ZERO_BIT = 4;
   // ------------------------------
   // timing
   // ------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int CYCLES_PER_MACHINE = 12;
   localparam logic [3:0] MC_LAST = 4'(CYCLES_PER_MACHINE - 1);
   localparam logic [3:0] SAMPLE_PHASE = 4'h9;   // input sample phase slot
   localparam logic [3:0] UPDATE_PHASE = 4'h4;   // count update phase slot
   localparam logic [4:0] PRESCALE_MAX = 5'h1F;
   // ------------------------------
   // operating modes
   // ------------------------------
   typedef enum logic [1:0] {
      DTC_MODE_PRESCALE = 2'h0,
      DTC_MODE_CASCADE = 2'h1,
      DTC_MODE_RELOAD = 2'h2,
      DTC_MODE_SPLIT = 2'h3
   } dtc_mode_t;
endpackage : dtc_pkg

// ### testbench/dtc_pins_model.sv
// outside world of the timer core: event pins and gating pins
// assumes the bench asks for bursts at clock edges; event pins idle high on pull-ups, gating pins follow gate_lvl
`timescale 1ns/10ps
`default_nettype none

module dtc_pins_model (
   input wire logic sys_clk,
   input wire logic start,
   input wire logic sel,
   input wire logic [7:0] pulses,
   input wire logic [1:0] gate_lvl,
   output logic event_pin_zero,
   output logic event_pin_one,
   output logic gating_pin_zero,
   output logic gating_pin_one,
   output logic busy
);
   assign gating_pin_zero = gate_lvl[0];
   assign gating_pin_one = gate_lvl[1];
   // each level is held longer than one machine cycle
   initial begin
      event_pin_zero = 1'b1;
      event_pin_one = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge sys_clk);
         if (start) begin
            busy <= 1'b1;
            for (int n = 0; n < int'(pulses); n++) begin
               repeat (13) @(posedge sys_clk);
               if (sel) event_pin_one <= 1'b0;
               else event_pin_zero <= 1'b0;
               repeat (17) @(posedge sys_clk);
               event_pin_one <= 1'b1;
               event_pin_zero <= 1'b1;
            end
            busy <= 1'b0;
         end
      end
   end
endmodule : dtc_pins_model

`default_nettype wire

// ### testbench/dtc_core_sva.sv
// checker for the timer core: register port and overflow flag timing
// assumes the core's machine-cycle phase starts at zero out of reset
`timescale 1ns/10ps
`default_nettype none

module dtc_core_sva (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] bit_mask,
   input wire logic vector_ack_zero,
   input wire logic vector_ack_one,
   input wire logic [7:0] reg_rdata,
   input wire logic overflow_flag_zero,
   input wire logic overflow_flag_one
);
   logic [3:0] phase;
   logic cnt_addr;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // local copy of the machine-cycle phase
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) phase <= 4'h0;
      else if (phase == dtc_pkg::MC_LAST) phase <= 4'h0;
      else phase <= phase + 4'h1;
   end
   // any of the four count bytes
   assign cnt_addr = reg_addr >= dtc_pkg::ADDR_LOW_BYTE_ZERO && reg_addr <= dtc_pkg::ADDR_HIGH_BYTE_ONE;
   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   a_mode_readback: assert property (
      (reg_wr && reg_addr == dtc_pkg::ADDR_TIMER_MODE_CONFIG) ##1 (reg_rd && $stable(reg_addr))
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("mode read back wrong");
   a_ctrl_readback: assert property (
      (reg_wr && reg_addr == dtc_pkg::ADDR_TIMER_CONTROL && bit_mask == 8'hFF) ##1 (reg_rd && $stable(reg_addr))
      |=> ((reg_rdata ^ $past(reg_wdata, 2)) & 8'h0F) == 8'h00) else $error("control read back wrong");
   a_count_readback: assert property (
      (reg_wr && cnt_addr) ##1 (reg_rd && $stable(reg_addr))
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("count byte read back wrong");
   a_flag_phase_zero: assert property (
      $rose(overflow_flag_zero) |-> $past(phase, 2) == dtc_pkg::UPDATE_PHASE || $past(reg_wr, 2))
      else $error("flag zero rose off the update phase");
   a_flag_phase_one: assert property (
      $rose(overflow_flag_one) |-> $past(phase, 2) == dtc_pkg::UPDATE_PHASE || $past(reg_wr, 2))
      else $error("flag one rose off the update phase");
   a_ack_clr_zero: assert property (
      vector_ack_zero && !reg_wr && phase != dtc_pkg::UPDATE_PHASE |-> ##2 !overflow_flag_zero)
      else $error("flag zero not cleared by ack");
   a_ack_clr_one: assert property (
      vector_ack_one && !reg_wr && phase != dtc_pkg::UPDATE_PHASE |-> ##2 !overflow_flag_one)
      else $error("flag one not cleared by ack");
   a_flag_fall_cause: assert property (
      $fell(overflow_flag_zero) |-> $past(vector_ack_zero, 2) || $past(reg_wr, 2))
      else $error("flag zero fell without cause");
   c_flag_zero: cover property ($rose(overflow_flag_zero));
   c_flag_one: cover property ($rose(overflow_flag_one));
   c_mode_read: cover property (reg_rd && reg_addr == dtc_pkg::ADDR_TIMER_MODE_CONFIG);
endmodule : dtc_core_sva

bind dtc_core dtc_core_sva chk (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .bit_mask(bit_mask), .vector_ack_zero(vector_ack_zero),
   .vector_ack_one(vector_ack_one), .reg_rdata(reg_rdata), .overflow_flag_zero(overflow_flag_zero),
   .overflow_flag_one(overflow_flag_one));

`default_nettype wire

// ### testbench/dual_timer_counter_core_test.sv
// self-checking bench for the dual timer/counter core
// assumes dtc_pkg, dtc_core, the pin model and the checker are compiled first
`timescale 1ns/10ps
`default_nettype none

module dual_timer_counter_core_test;
   localparam logic [7:0] CTL = dtc_pkg::ADDR_TIMER_CONTROL;
   localparam logic [7:0] MDC = dtc_pkg::ADDR_TIMER_MODE_CONFIG;
   localparam logic [7:0] LB0 = dtc_pkg::ADDR_LOW_BYTE_ZERO;
   localparam logic [7:0] LB1 = dtc_pkg::ADDR_LOW_BYTE_ONE;
   localparam logic [7:0] HB0 = dtc_pkg::ADDR_HIGH_BYTE_ZERO;
   localparam logic [7:0] HB1 = dtc_pkg::ADDR_HIGH_BYTE_ONE;
   logic sys_clk, rst, reg_wr, reg_rd, vector_ack_zero, vector_ack_one, start, sel, busy;
   logic [7:0] reg_addr, reg_wdata, bit_mask, reg_rdata, pulses;
   logic [1:0] gate_lvl;
   logic ev0, ev1, gt0, gt1, flag0, flag1;
   int num_errors, checked, cycles;
   dtc_core dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .bit_mask(bit_mask), .vector_ack_zero(vector_ack_zero), .vector_ack_one(vector_ack_one),
      .event_pin_zero(ev0), .event_pin_one(ev1), .gating_pin_zero(gt0), .gating_pin_one(gt1),
      .reg_rdata(reg_rdata), .overflow_flag_zero(flag0), .overflow_flag_one(flag1));
   dtc_pins_model model (.sys_clk(sys_clk), .start(start), .sel(sel), .pulses(pulses), .gate_lvl(gate_lvl),
      .event_pin_zero(ev0), .event_pin_one(ev1), .gating_pin_zero(gt0), .gating_pin_one(gt1), .busy(busy));
   // --------------------------------------------------------------
   // clock, timeout and closing report
   // --------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test
   // cut a hang short
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         $display("CHECK FAILED at %0t: timeout", $time);
         finish_test();
      end
   end
   // --------------------------------------------------------------
   // register port tasks
   // --------------------------------------------------------------
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp
   // optional write, then optional read straight after it
   task automatic xfer(input logic [7:0] a, input logic [7:0] d, input bit w, input bit r,
                       input logic [7:0] exp, input logic [7:0] m);
      reg_addr <= a;
      reg_wdata <= d;
      if (w) begin
         reg_wr <= 1'b1;
         @(posedge sys_clk);
         reg_wr <= 1'b0;
      end
      if (r) begin
         reg_rd <= 1'b1;
         @(posedge sys_clk);
         reg_rd <= 1'b0;
         #1 cmp(reg_rdata & m, exp & m, $sformatf("reg %h", a));
      end
      @(posedge sys_clk);
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(a, d, 1'b1, 1'b0, 8'h00, 8'h00);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
      xfer(a, 8'h00, 1'b0, 1'b1, exp, m);
   endtask : rd
   // run bits on for exactly 120 clocks, i.e. ten machine cycles; flags kept
   task automatic run120(input logic [7:0] on);
      bit_mask <= 8'h50;
      wr(CTL, on);
      repeat (118) @(posedge sys_clk);
      wr(CTL, 8'h00);
      bit_mask <= 8'hFF;
   endtask : run120
   task automatic ack(input bit one);
      vector_ack_zero <= !one;
      vector_ack_one <= one;
      @(posedge sys_clk);
      vector_ack_zero <= 1'b0;
      vector_ack_one <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 cmp({6'h0, flag1, flag0}, 8'h00, "flags after ack");
      @(posedge sys_clk);
   endtask : ack
   // burst of falling edges on one event pin, then time to land
   task automatic burst(input bit s, input logic [7:0] n);
      int t;
      t = 0;
      sel <= s;
      pulses <= n;
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
      @(posedge sys_clk);
      while (busy && t < 2000) begin
         @(posedge sys_clk);
         t++;
      end
      repeat (30) @(posedge sys_clk);
   endtask : burst
   // --------------------------------------------------------------
   // tests
   // --------------------------------------------------------------
   initial begin
      {rst, reg_wr, reg_rd, vector_ack_zero, vector_ack_one, start, sel} = 7'h40;
      {reg_addr, reg_wdata, pulses, gate_lvl} = 26'h0;
      bit_mask = 8'hFF;
      {num_errors, checked, cycles} = 96'h0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      for (int a = 8'h88; a <= 8'h8E; a++) rd(8'(a), 8'h00, 8'hFF);
      xfer(MDC, 8'hA5, 1'b1, 1'b1, 8'hA5, 8'hFF);
      xfer(CTL, 8'h0F, 1'b1, 1'b1, 8'h0F, 8'h0F);
      bit_mask <= 8'h01;
      xfer(CTL, 8'h00, 1'b1, 1'b1, 8'h0E, 8'h0F);
      bit_mask <= 8'hFF;
      wr(CTL, 8'h00);
      $display("test registers done");
      wr(MDC, 8'h01);
      wr(LB0, 8'hFB);
      wr(HB0, 8'hFF);
      run120(8'h10);
      rd(LB0, 8'h05, 8'hFF);
      rd(HB0, 8'h00, 8'hFF);
      rd(CTL, 8'h20, 8'hA0);
      cmp({7'h0, flag0}, 8'h01, "flag zero");
      ack(1'b0);
      wr(MDC, 8'h00);
      wr(LB0, 8'h1E);
      wr(HB0, 8'h40);
      run120(8'h10);
      rd(LB0, 8'h08, 8'h1F);
      rd(HB0, 8'h41, 8'hFF);
      wr(MDC, 8'h02);
      wr(HB0, 8'hF8);
      wr(LB0, 8'hFC);
      run120(8'h10);
      rd(LB0, 8'hFE, 8'hFF);
      rd(HB0, 8'hF8, 8'hFF);
      rd(CTL, 8'h20, 8'hA0);
      ack(1'b0);
      wr(MDC, 8'h03);
      wr(LB0, 8'h10);
      wr(HB0, 8'h00);
      run120(8'h40);
      rd(HB0, 8'h0A, 8'hFF);
      rd(LB0, 8'h10, 8'hFF);
      $display("test timer zero modes done");
      wr(MDC, 8'h10);
      wr(LB1, 8'hF8);
      wr(HB1, 8'hFF);
      run120(8'h40);
      rd(LB1, 8'h02, 8'hFF);
      rd(HB1, 8'h00, 8'hFF);
      rd(CTL, 8'h80, 8'hA0);
      ack(1'b1);
      wr(MDC, 8'h30);
      xfer(LB1, 8'h55, 1'b1, 1'b1, 8'h55, 8'hFF);
      run120(8'h40);
      rd(LB1, 8'h55, 8'hFF);
      gate_lvl <= 2'b00;
      wr(MDC, 8'h99);
      wr(LB0, 8'h00);
      wr(LB1, 8'h00);
      run120(8'h50);
      // raise the gates early: they pass two sync flops
      gate_lvl <= 2'b11;
      rd(LB0, 8'h00, 8'hFF);
      rd(LB1, 8'h00, 8'hFF);
      run120(8'h50);
      rd(LB0, 8'h0A, 8'hFF);
      rd(LB1, 8'h0A, 8'hFF);
      $display("test timer one and gating done");
      wr(MDC, 8'h55);
      wr(LB0, 8'h00);
      wr(LB1, 8'h00);
      bit_mask <= 8'h50;
      wr(CTL, 8'h50);
      burst(1'b0, 8'h05);
      burst(1'b1, 8'h03);
      wr(CTL, 8'h00);
      bit_mask <= 8'hFF;
      rd(LB0, 8'h05, 8'hFF);
      rd(LB1, 8'h03, 8'hFF);
      $display("test event counting done");
      finish_test();
   end
endmodule : dual_timer_counter_core_test

`default_nettype wire
